// [include/dnc_pkg.sv]
`default_nettype none
package dnc_pkg;
  // Bus geometry
  localparam int ADDR_W = 12;
  localparam int IDX_W  = 10;
  localparam int DATA_W = 32;
  localparam int IDX_LO = 2;
  localparam int IDX_HI = 11;

  // Register indices, byte address is four times the index
  localparam logic [9:0] IDX_XFER  = 10'h00F;
  localparam logic [9:0] IDX_SYNC  = 10'h300;
  localparam logic [9:0] IDX_CH0   = 10'h310;
  localparam logic [9:0] IDX_FREQ  = 10'h320;
  localparam logic [9:0] IDX_PHASE = 10'h321;
  localparam logic [9:0] IDX_MOD_A = 10'h322;
  localparam logic [9:0] IDX_MOD_B = 10'h323;
  localparam logic [9:0] IDX_SREF  = 10'h324;

  // Field positions
  localparam int XFER_BIT    = 0;
  localparam int UPD_MODE    = 7;
  localparam int SOFT_RST    = 4;
  localparam int NEXT_SYNC   = 1;
  localparam int SYNC_EN     = 0;
  localparam int MIX_SEL     = 7;
  localparam int GAIN_SEL    = 6;
  localparam int SREF_EN_BIT = 0;

  // Writable masks and reset values
  localparam logic [7:0]  SYNC_MASK = 8'h93;
  localparam logic [7:0]  CH0_MASK  = 8'hC0;
  localparam logic [7:0]  SREF_MASK = 8'h01;
  localparam logic [7:0]  CTRL_RST  = 8'h00;
  localparam logic [31:0] WORD_RST  = 32'h0000_0000;

  // Responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [31:0] freq_tuning_word;
    logic [31:0] phase_offset_word;
    logic [31:0] modulus_a_word;
    logic [31:0] modulus_b_word;
  } dnc_words_t;

  typedef struct packed {
    logic nco_reset;
    logic nco_align;
    logic mixer_complex;
    logic gain_double;
  } dnc_nco_ctrl_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RESP = 2'b10
  } dnc_wr_st_t;
endpackage : dnc_pkg
`default_nettype wire

// [logic/dnc_sync_ctrl.sv]
// Summary of operation
// - Update mode 0: written tuning, phase and modulus words take effect at once.
// - Update mode 1: words wait pending until the transfer strobe applies them together.
// - Soft-reset bit high holds all downconverters in reset; low runs them.
// - Next-sync mode aligns on the next valid timing edge, ignoring all later.
// - Next-sync mode clears the enable bit once its edge was used.
// - Enable low, or timing input disabled, means no edge-based alignment.
// - Mixer-select bit picks real mixer at 0, complex quadrature mixer at 1.
// - Gain-select bit gives 0 dB at 0, times two at 1.
`default_nettype none
module dnc_sync_ctrl (
  input  wire logic                  clk,
  input  wire logic                  resetn,
  input  wire logic [11:0]           s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [11:0]           s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  sysref_i,
  output dnc_pkg::dnc_words_t        nco_words,
  output dnc_pkg::dnc_nco_ctrl_t     nco_ctrl
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Byte-lane merge of a write into a word
  function automatic logic [31:0] dnc_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : dnc_merge

  // Whether an index names a register
  function automatic logic dnc_mapped(input logic [9:0] idx);
    return (idx == dnc_pkg::IDX_XFER) || (idx == dnc_pkg::IDX_SYNC) ||
           (idx == dnc_pkg::IDX_CH0)   || (idx == dnc_pkg::IDX_FREQ)  ||
           (idx == dnc_pkg::IDX_PHASE) || (idx == dnc_pkg::IDX_MOD_A) ||
           (idx == dnc_pkg::IDX_MOD_B) || (idx == dnc_pkg::IDX_SREF);
  endfunction : dnc_mapped

  ////////////////////////////////////////////////////////////////////////////
  // State

  dnc_pkg::dnc_wr_st_t    wst_ff,    nxt_wst;
  logic                   aw_got_ff, nxt_aw_got;
  logic                   w_got_ff,  nxt_w_got;
  logic [9:0]             awidx_ff,  nxt_awidx;
  logic [31:0]            wdata_ff,  nxt_wdata;
  logic [3:0]             wstrb_ff,  nxt_wstrb;
  logic [1:0]             bresp_ff,  nxt_bresp;
  logic                   rvalid_ff, nxt_rvalid;
  logic [31:0]            rdata_ff,  nxt_rdata;
  logic [1:0]             rresp_ff,  nxt_rresp;
  logic [7:0]             sync_ff,   nxt_sync;
  logic [7:0]             ch0_ff,    nxt_ch0;
  logic [7:0]             sref_ff,   nxt_sref;
  dnc_pkg::dnc_words_t    pend_ff,   nxt_pend;
  dnc_pkg::dnc_words_t    act_ff,    nxt_act;
  dnc_pkg::dnc_nco_ctrl_t ctrl_ff,   nxt_ctrl;
  logic                   sysref_prev_ff;
  logic                   wr_go;
  logic                   sync_wr;
  logic                   xfer_go;
  logic                   sref_edge;
  logic                   sync_go;
  logic [9:0]             wr_idx;
  logic [9:0]             rd_idx;
  logic [31:0]            wr_data;
  logic [3:0]             wr_strb;

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshakes and outputs

  assign s_axi_awready = (wst_ff == dnc_pkg::ST_IDLE) && !aw_got_ff;
  assign s_axi_wready  = (wst_ff == dnc_pkg::ST_IDLE) && !w_got_ff;
  assign s_axi_bvalid  = (wst_ff == dnc_pkg::ST_RESP);
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;
  assign nco_words     = act_ff;
  assign nco_ctrl      = ctrl_ff;

  // Write commit once address and data are both held or arriving
  assign wr_idx  = aw_got_ff ? awidx_ff : s_axi_awaddr[dnc_pkg::IDX_HI:dnc_pkg::IDX_LO];
  assign wr_data = w_got_ff ? wdata_ff : s_axi_wdata;
  assign wr_strb = w_got_ff ? wstrb_ff : s_axi_wstrb;
  assign wr_go   = s_axi_awready | s_axi_wready ?
                   ((aw_got_ff | s_axi_awvalid) & (w_got_ff | s_axi_wvalid)) : 1'b0;
  assign sync_wr = wr_go && (wr_idx == dnc_pkg::IDX_SYNC) && wr_strb[0];
  assign xfer_go = wr_go && (wr_idx == dnc_pkg::IDX_XFER) && wr_strb[0]
                   && wr_data[dnc_pkg::XFER_BIT];
  assign rd_idx  = s_axi_araddr[dnc_pkg::IDX_HI:dnc_pkg::IDX_LO];

  // Timing edge qualified by both enables
  assign sref_edge = sysref_i && !sysref_prev_ff;
  assign sync_go   = sref_edge && sync_ff[dnc_pkg::SYNC_EN]
                     && sref_ff[dnc_pkg::SREF_EN_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    nxt_wst    = wst_ff;
    nxt_aw_got = aw_got_ff;
    nxt_w_got  = w_got_ff;
    nxt_awidx  = awidx_ff;
    nxt_wdata  = wdata_ff;
    nxt_wstrb  = wstrb_ff;
    nxt_bresp  = bresp_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rdata  = rdata_ff;
    nxt_rresp  = rresp_ff;
    nxt_sync   = sync_ff;
    nxt_ch0    = ch0_ff;
    nxt_sref   = sref_ff;
    nxt_pend   = pend_ff;
    nxt_act    = act_ff;
    // Write channel sequencing
    case (wst_ff)
      dnc_pkg::ST_IDLE: begin
        if (wr_go) begin
          nxt_wst    = dnc_pkg::ST_RESP;
          nxt_aw_got = 1'b0;
          nxt_w_got  = 1'b0;
          nxt_bresp  = dnc_mapped(wr_idx) ? dnc_pkg::RESP_OKAY : dnc_pkg::RESP_SLVERR;
        end else begin
          if (s_axi_awvalid && s_axi_awready) begin
            nxt_aw_got = 1'b1;
            nxt_awidx  = s_axi_awaddr[dnc_pkg::IDX_HI:dnc_pkg::IDX_LO];
          end
          if (s_axi_wvalid && s_axi_wready) begin
            nxt_w_got = 1'b1;
            nxt_wdata = s_axi_wdata;
            nxt_wstrb = s_axi_wstrb;
          end
        end
      end
      dnc_pkg::ST_RESP: begin
        if (s_axi_bready) begin
          nxt_wst = dnc_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_wst = dnc_pkg::ST_IDLE;
      end
    endcase
    // One-shot alignment drops the enable; a software write wins
    if (sync_go && sync_ff[dnc_pkg::NEXT_SYNC]) begin
      nxt_sync[dnc_pkg::SYNC_EN] = 1'b0;
    end
    // Register writes
    if (wr_go) begin
      case (wr_idx)
        dnc_pkg::IDX_SYNC: begin
          if (wr_strb[0]) nxt_sync = wr_data[7:0] & dnc_pkg::SYNC_MASK;
        end
        dnc_pkg::IDX_CH0: begin
          if (wr_strb[0]) nxt_ch0 = wr_data[7:0] & dnc_pkg::CH0_MASK;
        end
        dnc_pkg::IDX_SREF: begin
          if (wr_strb[0]) nxt_sref = wr_data[7:0] & dnc_pkg::SREF_MASK;
        end
        dnc_pkg::IDX_FREQ: begin
          nxt_pend.freq_tuning_word =
            dnc_merge(pend_ff.freq_tuning_word, wr_data, wr_strb);
        end
        dnc_pkg::IDX_PHASE: begin
          nxt_pend.phase_offset_word =
            dnc_merge(pend_ff.phase_offset_word, wr_data, wr_strb);
        end
        dnc_pkg::IDX_MOD_A: begin
          nxt_pend.modulus_a_word = dnc_merge(pend_ff.modulus_a_word, wr_data, wr_strb);
        end
        dnc_pkg::IDX_MOD_B: begin
          nxt_pend.modulus_b_word = dnc_merge(pend_ff.modulus_b_word, wr_data, wr_strb);
        end
        default: begin
        end
      endcase
    end
    // Word update policy
    if (!sync_ff[dnc_pkg::UPD_MODE]) begin
      nxt_act = nxt_pend;
    end else if (xfer_go) begin
      nxt_act = pend_ff;
    end
    // Read channel
    if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      nxt_rvalid = 1'b1;
      nxt_rresp  = dnc_mapped(rd_idx) ? dnc_pkg::RESP_OKAY : dnc_pkg::RESP_SLVERR;
      case (rd_idx)
        dnc_pkg::IDX_SYNC:  nxt_rdata = {24'h00_0000, sync_ff};
        dnc_pkg::IDX_CH0:   nxt_rdata = {24'h00_0000, ch0_ff};
        dnc_pkg::IDX_SREF:  nxt_rdata = {24'h00_0000, sref_ff};
        dnc_pkg::IDX_FREQ:  nxt_rdata = pend_ff.freq_tuning_word;
        dnc_pkg::IDX_PHASE: nxt_rdata = pend_ff.phase_offset_word;
        dnc_pkg::IDX_MOD_A: nxt_rdata = pend_ff.modulus_a_word;
        dnc_pkg::IDX_MOD_B: nxt_rdata = pend_ff.modulus_b_word;
        default:            nxt_rdata = dnc_pkg::WORD_RST;
      endcase
    end
    // Oscillator controls toward the datapath
    nxt_ctrl.nco_reset     = sync_ff[dnc_pkg::SOFT_RST];
    nxt_ctrl.nco_align     = sync_go;
    nxt_ctrl.mixer_complex = ch0_ff[dnc_pkg::MIX_SEL];
    nxt_ctrl.gain_double   = ch0_ff[dnc_pkg::GAIN_SEL];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wst_ff         <= dnc_pkg::ST_IDLE;
      aw_got_ff      <= 1'b0;
      w_got_ff       <= 1'b0;
      awidx_ff       <= 10'h000;
      wdata_ff       <= dnc_pkg::WORD_RST;
      wstrb_ff       <= 4'h0;
      bresp_ff       <= dnc_pkg::RESP_OKAY;
      rvalid_ff      <= 1'b0;
      rdata_ff       <= dnc_pkg::WORD_RST;
      rresp_ff       <= dnc_pkg::RESP_OKAY;
      sync_ff        <= dnc_pkg::CTRL_RST;
      ch0_ff         <= dnc_pkg::CTRL_RST;
      sref_ff        <= dnc_pkg::CTRL_RST;
      pend_ff        <= '0;
      act_ff         <= '0;
      ctrl_ff        <= '0;
      sysref_prev_ff <= 1'b0;
    end else begin
      wst_ff         <= nxt_wst;
      aw_got_ff      <= nxt_aw_got;
      w_got_ff       <= nxt_w_got;
      awidx_ff       <= nxt_awidx;
      wdata_ff       <= nxt_wdata;
      wstrb_ff       <= nxt_wstrb;
      bresp_ff       <= nxt_bresp;
      rvalid_ff      <= nxt_rvalid;
      rdata_ff       <= nxt_rdata;
      rresp_ff       <= nxt_rresp;
      sync_ff        <= nxt_sync;
      ch0_ff         <= nxt_ch0;
      sref_ff        <= nxt_sref;
      pend_ff        <= nxt_pend;
      act_ff         <= nxt_act;
      ctrl_ff        <= nxt_ctrl;
      sysref_prev_ff <= sysref_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_oneshot_hit;
    sync_go && sync_ff[dnc_pkg::NEXT_SYNC] && !sync_wr;
  endsequence

  sequence s_cont_hit;
    sync_go && !sync_ff[dnc_pkg::NEXT_SYNC] && !sync_wr;
  endsequence

  chk_immediate_update: assert property (@(posedge clk) disable iff (!resetn)
    !sync_ff[dnc_pkg::UPD_MODE] |=> act_ff == pend_ff)
    else $error("words not applied at once in update mode 0");
  chk_transfer_apply: assert property (@(posedge clk) disable iff (!resetn)
    sync_ff[dnc_pkg::UPD_MODE] && xfer_go |=> act_ff == $past(pend_ff))
    else $error("transfer strobe did not apply pending words");
  chk_pending_hold: assert property (@(posedge clk) disable iff (!resetn)
    sync_ff[dnc_pkg::UPD_MODE] && !xfer_go |=> $stable(act_ff))
    else $error("active words changed without transfer strobe");
  chk_soft_reset: assert property (@(posedge clk) disable iff (!resetn)
    sync_wr && wr_data[dnc_pkg::SOFT_RST] |=> ##1 ctrl_ff.nco_reset)
    else $error("soft reset not driven to oscillators");
  chk_oneshot_clear: assert property (@(posedge clk) disable iff (!resetn)
    s_oneshot_hit |=> !sync_ff[dnc_pkg::SYNC_EN] ##0 ctrl_ff.nco_align)
    else $error("one-shot sync did not clear enable");
  chk_oneshot_ignore: assert property (@(posedge clk) disable iff (!resetn)
    s_oneshot_hit ##1 !sync_wr |=> !ctrl_ff.nco_align)
    else $error("later edge used after one-shot sync");
  chk_align_cause: assert property (@(posedge clk) disable iff (!resetn)
    ctrl_ff.nco_align |-> $past(sync_ff[dnc_pkg::SYNC_EN] && sref_ff[dnc_pkg::SREF_EN_BIT]))
    else $error("alignment without both enables");
  chk_continuous_keep: assert property (@(posedge clk) disable iff (!resetn)
    s_cont_hit |=> sync_ff[dnc_pkg::SYNC_EN] && ctrl_ff.nco_align)
    else $error("continuous sync dropped enable or alignment");
  chk_mixer_select: assert property (@(posedge clk) disable iff (!resetn)
    wr_go && wr_idx == dnc_pkg::IDX_CH0 && wr_strb[0]
    |=> ##1 ctrl_ff.mixer_complex == $past(wr_data[dnc_pkg::MIX_SEL], 2))
    else $error("mixer type does not follow register");
  chk_gain_select: assert property (@(posedge clk) disable iff (!resetn)
    wr_go && wr_idx == dnc_pkg::IDX_CH0 && wr_strb[0]
    |=> ##1 ctrl_ff.gain_double == $past(wr_data[dnc_pkg::GAIN_SEL], 2))
    else $error("gain does not follow register");

endmodule : dnc_sync_ctrl
`default_nettype wire

// [sim/dnc_sysref_src.sv]
`default_nettype none
module dnc_sysref_src #(
  parameter int PERIOD = 8
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       start,
  input  wire logic [3:0] count,
  output logic            sysref
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] left_ff;
  logic [7:0] ph_ff;
  ////////////////////////////////////////////////////////////////////////
  // Pulse train, period a whole multiple of the oscillator, idle low
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      left_ff <= 4'h0;
      ph_ff   <= 8'h00;
      sysref  <= 1'b0;
    end else if (start) begin
      left_ff <= count;
      ph_ff   <= 8'h00;
    end else if (left_ff != 4'h0) begin
      sysref <= (ph_ff < 8'h02);
      if (ph_ff == 8'(PERIOD - 1)) begin
        ph_ff   <= 8'h00;
        left_ff <= left_ff - 4'h1;
      end else begin
        ph_ff <= ph_ff + 8'h01;
      end
    end else begin
      sysref <= 1'b0;
    end
  end
endmodule : dnc_sysref_src
`default_nettype wire

// [sim/test_ddc_nco_sync_control.sv]
`default_nettype none
module test_ddc_nco_sync_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, resetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, start = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, d, e, f, g;
  logic [3:0] count = 4'h0, wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, sysref;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] cnt = 8'h00, base;
  dnc_pkg::dnc_words_t    words;
  dnc_pkg::dnc_nco_ctrl_t ctrl;
  logic [1:0]  bq[$];
  logic [33:0] rq[$];
  int failures = 0, num_checks = 0;
  localparam logic [11:0] A_SYNC = {dnc_pkg::IDX_SYNC, 2'b00};
  localparam logic [11:0] A_CH0  = {dnc_pkg::IDX_CH0, 2'b00};
  localparam logic [11:0] A_SREF = {dnc_pkg::IDX_SREF, 2'b00};
  localparam logic [11:0] A_FREQ = {dnc_pkg::IDX_FREQ, 2'b00};
  localparam logic [11:0] A_PHS  = {dnc_pkg::IDX_PHASE, 2'b00};
  localparam logic [11:0] A_MODA = {dnc_pkg::IDX_MOD_A, 2'b00};
  localparam logic [11:0] A_MODB = {dnc_pkg::IDX_MOD_B, 2'b00};
  localparam logic [1:0]  OK     = dnc_pkg::RESP_OKAY;

  dnc_sync_ctrl uut (.clk(clk), .resetn(resetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sysref_i(sysref), .nco_words(words), .nco_ctrl(ctrl));
  dnc_sysref_src #(.PERIOD(8)) src (.clk(clk), .resetn(resetn), .start(start),
    .count(count), .sysref(sysref));

  always #4 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////
  // Report and end
  task automatic summarize;
    if (failures == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  task automatic chk_val(input logic [33:0] got, input logic [33:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_val
  // Write response against the oldest note
  task automatic chk_bresp(input logic [1:0] got);
    logic [1:0] exp;
    num_checks++;
    if (bq.size() == 0) begin
      failures++;
      $display("unexpected at %0t: got %h expected none", $time, got);
    end else begin
      exp = bq.pop_front();
      if (got !== exp) begin
        failures++;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask : chk_bresp
  // Read response and data against the oldest note
  task automatic chk_read(input logic [33:0] got);
    logic [33:0] exp;
    num_checks++;
    if (rq.size() == 0) begin
      failures++;
      $display("unexpected at %0t: got %h expected none", $time, got);
    end else begin
      exp = rq.pop_front();
      if (got !== exp) begin
        failures++;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask : chk_read
  // Write cycle, address and data offered together
  task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] r);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    bq.push_back(r);
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge clk);
      if (!ad && awready) begin ad = 1'b1; awvalid <= 1'b0; end
      if (!wd && wready) begin wd = 1'b1; wvalid <= 1'b0; end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask : wr
  // Read cycle, expectation noted for the monitor
  task automatic rd(input logic [11:0] a, input logic [31:0] v, input logic [1:0] r);
    rq.push_back({r, v});
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge clk);
    rready <= 1'b0;
  endtask : rd
  task automatic settle;
    repeat (3) @(posedge clk);
  endtask : settle
  task automatic fire(input logic [3:0] n);
    base = cnt;
    @(posedge clk);
    start <= 1'b1;
    count <= n;
    @(posedge clk);
    start <= 1'b0;
    repeat (8 * n + 6) @(posedge clk);
  endtask : fire
  ////////////////////////////////////////////////////////////////////////
  // Monitor: responses against the oldest note, alignment pulses counted
  always @(posedge clk) begin
    if (bvalid === 1'b1 && bready === 1'b1) chk_bresp(bresp);
    if (rvalid === 1'b1 && rready === 1'b1) chk_read({rresp, rdata});
    if (ctrl.nco_align === 1'b1) cnt <= cnt + 8'h01;
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    summarize();
  end
  // Main sequence
  initial begin
    void'($urandom(18));
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    rd(A_SYNC, 32'h0, OK);
    rd(A_CH0, 32'h0, OK);
    d = $urandom;
    wr(A_FREQ, d, OK);
    settle();
    chk_val(34'(words.freq_tuning_word), 34'(d));
    wr(A_SYNC, 32'h80, OK);
    e = $urandom;
    f = $urandom;
    g = $urandom;
    wr(A_PHS, e, OK);
    wr(A_MODA, f, OK);
    wr(A_MODB, g, OK);
    rd(A_PHS, e, OK);
    settle();
    chk_val(34'(words.phase_offset_word), 34'h0);
    chk_val(34'(words.modulus_a_word), 34'h0);
    chk_val(34'(words.modulus_b_word), 34'h0);
    chk_val(34'(words.freq_tuning_word), 34'(d));
    wr({dnc_pkg::IDX_XFER, 2'b00}, 32'h1, OK);
    settle();
    chk_val(34'(words.phase_offset_word), 34'(e));
    chk_val(34'(words.modulus_a_word), 34'(f));
    chk_val(34'(words.modulus_b_word), 34'(g));
    wr(A_SYNC, 32'hFF, OK);
    rd(A_SYNC, 32'h93, OK);
    settle();
    chk_val(34'(ctrl.nco_reset), 34'h1);
    wr(A_SYNC, 32'h0, OK);
    settle();
    chk_val(34'(ctrl.nco_reset), 34'h0);
    wr(A_CH0, 32'hFF, OK);
    rd(A_CH0, 32'hC0, OK);
    settle();
    chk_val(34'({ctrl.mixer_complex, ctrl.gain_double}), 34'h3);
    wr(A_CH0, 32'h40, OK);
    settle();
    chk_val(34'({ctrl.mixer_complex, ctrl.gain_double}), 34'h1);
    wr(A_SYNC, 32'h01, OK);
    fire(4'h2);
    chk_val(34'(cnt - base), 34'h0);
    wr(A_SREF, 32'h1, OK);
    wr(A_SYNC, 32'h00, OK);
    fire(4'h2);
    chk_val(34'(cnt - base), 34'h0);
    wr(A_SYNC, 32'h03, OK);
    fire(4'h3);
    chk_val(34'(cnt - base), 34'h1);
    rd(A_SYNC, 32'h02, OK);
    wr(A_SYNC, 32'h01, OK);
    fire(4'h3);
    chk_val(34'(cnt - base), 34'h3);
    rd(A_SYNC, 32'h01, OK);
    // Low byte lane only, update mode 0 applies it at once
    wstrb <= 4'h1;
    wr(A_FREQ, 32'hFFFF_FFFF, OK);
    wstrb <= 4'hF;
    settle();
    chk_val(34'(words.freq_tuning_word), 34'({d[31:8], 8'hFF}));
    wr(12'h004, 32'hFFFF_FFFF, dnc_pkg::RESP_SLVERR);
    rd(12'h004, 32'h0, dnc_pkg::RESP_SLVERR);
    settle();
    summarize();
  end
endmodule : test_ddc_nco_sync_control
`default_nettype wire
